// [design/eeprom_port.sv]
// command port and array of a 4096-bit serial nonvolatile memory
// assumes the pins arrive asynchronously and are slow against mclk
//
// Contract
// - array of 4096 bits, read as 16-bit or 8-bit words by width pin.
// - instruction is 11 bits for 16-bit words, 12 bits for 8-bit words.
// - input bits are sampled at each rising shift clock edge.
// - data output floats except for read data or ready/busy status.
// - after a cycle starts and select rises, output low busy, high ready.
// - a 1 shifted in during status returns the output to float.
// - start bit, 2-bit opcode, 8 or 9 address bits, then write data.
// - read uses opcode 10 plus the word address.
// - single clear uses opcode 11 plus the word address.
// - single program uses opcode 01, address, then one data word, msb first.
// - enable uses opcode 00 with leading address bits 11.
// - disable uses opcode 00 with leading bits 00, blocking program and clear.
// - read drives a dummy zero, then the word msb first.
// - read data changes on each rising shift clock edge.
// - continued clocking reads the next word, wrapping at top to 0.
// - only the first word of a sequential read has the dummy zero.
// - enable latch clears at power-up; program and clear ignored until enabled.
// - enable latch stays set until reset or a disable instruction.
// - reads work whatever the enable latch holds.
// - self-timed cycle ends within 5 ms, then ready is reported.
// - falling select after a full program instruction starts the cycle.
// - a cleared location reads back as all ones.
// - program clears the location itself before storing.
// - fill-all writes its word to every location in one timed cycle.
module eeprom_port
    import eeprom_pkg::*;
#(
    parameter int PROG_CYCLES_P = PROG_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // serial pins
    input wire logic chip_select,
    input wire logic shift_clock,
    input wire logic serial_in,
    input wire logic word_width_select,
    output logic serial_out,
    output logic serial_out_en,
    // state seen from outside
    output logic cycle_busy,
    output logic program_enabled
);

    generate
        if (PROG_CYCLES_P < MEM_BYTES) begin : g_bad
            $error("program cycle too short to sweep the array");
        end
    endgenerate

    // ==========================================================
    // pin synchronisation
    logic [3:0] pins;
    logic cs_s;
    logic sk_s;
    logic si_s;
    logic x16_s;

    pin_filter #(.W(4)) u_filter (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pin_raw({word_width_select, serial_in, shift_clock, chip_select}),
        .pin_level(pins)
    );

    assign cs_s = pins[0];
    assign sk_s = pins[1];
    assign si_s = pins[2];
    assign x16_s = pins[3];

    logic cs_prev_reg;
    logic sk_prev_reg;
    wire sk_rise = sk_s & ~sk_prev_reg & cs_s;
    wire cs_rise = cs_s & ~cs_prev_reg;
    wire cs_fall = ~cs_s & cs_prev_reg;

    // ==========================================================
    // array, held as bytes; a 16-bit word a is bytes 2a (high) and 2a+1
    logic [7:0] mem [0:MEM_BYTES-1];

    function automatic logic [15:0] fetch_word(input logic [MEM_AW-1:0] a, input logic x16);
        logic [15:0] w;
        w = 16'h0000;
        if (x16) begin
            w = {mem[{a[7:0], 1'b0}], mem[{a[7:0], 1'b1}]};
        end else begin
            // byte words are left aligned so the msb always sits at bit 15
            w = {mem[a], 8'h00};
        end
        return w;
    endfunction

    function automatic logic [MEM_AW-1:0] next_addr(input logic [MEM_AW-1:0] a, input logic x16);
        logic [MEM_AW-1:0] n;
        n = a + 1'b1;
        if (x16) begin
            n = {1'b0, n[7:0]};
        end
        return n;
    endfunction

    // ==========================================================
    // state
    port_state_t state_reg, state_next;
    op_t pend_reg, pend_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [10:0] head_reg, head_next;
    logic [15:0] data_reg, data_next;
    logic [MEM_AW-1:0] addr_reg, addr_next;
    logic [15:0] out_reg, out_next;
    logic wel_reg, wel_next;
    logic status_reg, status_next;
    logic do_reg, do_next;
    logic do_en_reg, do_en_next;
    logic x16_reg, x16_next;

    // self-timed execution
    op_t ex_op_reg;
    logic [MEM_AW-1:0] ex_ptr_reg;
    logic [9:0] ex_left_reg;
    logic [15:0] ex_data_reg;
    logic ex_x16_reg;
    logic timer_running;
    logic ex_start;

    // ==========================================================
    // instruction decode
    wire [10:0] head_in = {head_reg[9:0], si_s};
    wire [4:0] head_len = x16_reg ? HEAD_BITS_X16 : HEAD_BITS_X8;
    wire [4:0] data_len = x16_reg ? DATA_BITS_X16 : DATA_BITS_X8;
    wire [1:0] opc = x16_reg ? head_in[9:8] : head_in[10:9];
    wire [1:0] ext = x16_reg ? head_in[7:6] : head_in[8:7];
    wire [MEM_AW-1:0] op_addr = x16_reg ? {1'b0, head_in[7:0]} : head_in[8:0];
    wire head_done = (cnt_reg == head_len - 5'h01);
    wire data_done = (cnt_reg == data_len - 5'h01);
    wire [15:0] data_in = {data_reg[14:0], si_s};
    wire [MEM_AW-1:0] rd_next_addr = next_addr(addr_reg, x16_reg);
    wire [15:0] rd_next_word = fetch_word(rd_next_addr, x16_reg);
    wire [15:0] rd_first_word = fetch_word(op_addr, x16_reg);
    assign cycle_busy = timer_running | (ex_left_reg != 10'h000);

    // ==========================================================
    // port sequencing
    always_comb begin
        state_next = state_reg;
        pend_next = pend_reg;
        cnt_next = cnt_reg;
        head_next = head_reg;
        data_next = data_reg;
        addr_next = addr_reg;
        out_next = out_reg;
        wel_next = wel_reg;
        status_next = status_reg;
        do_next = do_reg;
        do_en_next = do_en_reg;
        x16_next = x16_reg;
        if (!cs_s) begin
            // deselect ends any frame and floats the output
            state_next = ST_IDLE;
            do_en_next = 1'b0;
            pend_next = OP_NONE;
        end else if (cs_rise && status_reg) begin
            // the status level must be fresh as the pin starts driving, not a stale bit
            do_en_next = 1'b1;
            do_next = ~cycle_busy;
        end else if (sk_rise) begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (si_s) begin
                        if (status_reg) begin
                            status_next = 1'b0;
                            do_en_next = 1'b0;
                        end
                        // new instructions wait until the timed cycle ends
                        if (!cycle_busy) begin
                            state_next = ST_HEAD;
                            cnt_next = 5'h00;
                            x16_next = x16_s;
                        end
                    end
                end
                ST_HEAD: begin
                    head_next = head_in;
                    cnt_next = cnt_reg + 5'h01;
                    if (head_done) begin
                        state_next = ST_IDLE;
                        addr_next = op_addr;
                        cnt_next = 5'h00;
                        unique case (opc)
                            OPC_READ: begin
                                // reads ignore the enable latch
                                state_next = ST_READ;
                                out_next = rd_first_word;
                                do_next = 1'b0;
                                do_en_next = 1'b1;
                            end
                            OPC_CLEAR: begin
                                pend_next = wel_reg ? OP_CLEAR : OP_NONE;
                            end
                            OPC_PROGRAM: begin
                                state_next = ST_DATA;
                            end
                            OPC_EXT: begin
                                unique case (ext)
                                    EXT_ENABLE: wel_next = 1'b1;
                                    EXT_DISABLE: wel_next = 1'b0;
                                    EXT_CLEAR_ALL: begin
                                        pend_next = wel_reg ? OP_CLEAR_ALL : OP_NONE;
                                    end
                                    EXT_FILL_ALL: state_next = ST_DATA;
                                endcase
                            end
                        endcase
                    end
                end
                ST_DATA: begin
                    data_next = data_in;
                    cnt_next = cnt_reg + 5'h01;
                    if (data_done) begin
                        // extra clocks with serial_in low after the data word are ignored
                        state_next = ST_IDLE;
                        if (wel_reg) begin
                            pend_next = (opc == OPC_EXT) ? OP_FILL_ALL : OP_PROGRAM;
                        end
                    end
                end
                ST_READ: begin
                    if (cnt_reg < data_len) begin
                        do_next = out_reg[15];
                        out_next = {out_reg[14:0], 1'b0};
                        cnt_next = cnt_reg + 5'h01;
                    end else begin
                        // no dummy bit between sequential words
                        addr_next = rd_next_addr;
                        do_next = rd_next_word[15];
                        out_next = {rd_next_word[14:0], 1'b0};
                        cnt_next = 5'h01;
                    end
                end
            endcase
        end
        if (ex_start) begin
            status_next = 1'b1;
        end
        if (status_reg && cs_s && do_en_reg) begin
            do_next = ~cycle_busy;
        end
    end

    // ==========================================================
    // timed cycle start on falling select
    assign ex_start = cs_fall && (pend_reg != OP_NONE) && !cycle_busy;

    cycle_timer #(.CYCLES(PROG_CYCLES_P)) u_timer (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .start(ex_start),
        .running(timer_running)
    );

    wire ex_all = (pend_reg == OP_CLEAR_ALL) || (pend_reg == OP_FILL_ALL);
    wire [MEM_AW-1:0] ex_first = ex_all ? '0 : (x16_reg ? {addr_reg[7:0], 1'b0} : addr_reg);
    wire [9:0] ex_count = ex_all ? 10'h200 : (x16_reg ? 10'h002 : 10'h001);
    wire ex_erase = (ex_op_reg == OP_CLEAR) || (ex_op_reg == OP_CLEAR_ALL);
    // program overwrites whole bytes, so no separate clear pass is needed
    wire [7:0] ex_byte = ex_erase ? ERASED_BYTE :
        (!ex_x16_reg || ex_ptr_reg[0]) ? ex_data_reg[7:0] : ex_data_reg[15:8];
    wire ex_write = (ex_left_reg != 10'h000);

    // ==========================================================
    // registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            pend_reg <= OP_NONE;
            cnt_reg <= 5'h00;
            head_reg <= 11'h000;
            data_reg <= 16'h0000;
            addr_reg <= '0;
            out_reg <= 16'h0000;
            wel_reg <= 1'b0;
            status_reg <= 1'b0;
            do_reg <= 1'b0;
            do_en_reg <= 1'b0;
            x16_reg <= 1'b1;
            cs_prev_reg <= 1'b0;
            sk_prev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            pend_reg <= pend_next;
            cnt_reg <= cnt_next;
            head_reg <= head_next;
            data_reg <= data_next;
            addr_reg <= addr_next;
            out_reg <= out_next;
            wel_reg <= wel_next;
            status_reg <= status_next;
            do_reg <= do_next;
            do_en_reg <= do_en_next;
            x16_reg <= x16_next;
            cs_prev_reg <= cs_s;
            sk_prev_reg <= sk_s;
        end
    end

    // one byte per clock; a full sweep of 512 bytes fits well inside the cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ex_op_reg <= OP_NONE;
            ex_ptr_reg <= '0;
            ex_left_reg <= 10'h000;
            ex_data_reg <= 16'h0000;
            ex_x16_reg <= 1'b1;
        end else if (ex_start) begin
            ex_op_reg <= pend_reg;
            ex_ptr_reg <= ex_first;
            ex_left_reg <= ex_count;
            ex_data_reg <= x16_reg ? data_reg : {8'h00, data_reg[7:0]};
            ex_x16_reg <= x16_reg;
        end else if (ex_write) begin
            ex_ptr_reg <= ex_ptr_reg + 1'b1;
            ex_left_reg <= ex_left_reg - 10'h001;
        end
    end

    // array storage has no reset: contents are data, not control
    always_ff @(posedge mclk) begin
        if (ex_write) begin
            mem[ex_ptr_reg] <= ex_byte;
        end
    end

    // ==========================================================
    // outputs
    assign serial_out = do_reg;
    assign serial_out_en = do_en_reg;
    assign program_enabled = wel_reg;

endmodule

// [design/eeprom_pkg.sv]
// constants shared by the serial nonvolatile memory command port
// assumes a single 50 MHz system clock feeding every module
package eeprom_pkg;

    // ==========================================================
    // clock and self-timed cycle
    localparam int CLK_HZ = 50_000_000;
    localparam int PROG_TIME_MS = 5;
    // a longest time rounds down to whole cycles
    localparam int PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);

    // ==========================================================
    // array geometry
    localparam int MEM_BYTES = 512;
    localparam int MEM_AW = 9;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // ==========================================================
    // instruction framing: bits after the start bit
    localparam logic [4:0] HEAD_BITS_X16 = 5'h0A;
    localparam logic [4:0] HEAD_BITS_X8 = 5'h0B;
    localparam logic [4:0] DATA_BITS_X16 = 5'h10;
    localparam logic [4:0] DATA_BITS_X8 = 5'h08;

    // ==========================================================
    // opcodes and extended codes in the leading address bits
    localparam logic [1:0] OPC_EXT = 2'h0;
    localparam logic [1:0] OPC_PROGRAM = 2'h1;
    localparam logic [1:0] OPC_READ = 2'h2;
    localparam logic [1:0] OPC_CLEAR = 2'h3;
    localparam logic [1:0] EXT_DISABLE = 2'h0;
    localparam logic [1:0] EXT_FILL_ALL = 2'h1;
    localparam logic [1:0] EXT_CLEAR_ALL = 2'h2;
    localparam logic [1:0] EXT_ENABLE = 2'h3;

    typedef enum logic [1:0] {ST_IDLE, ST_HEAD, ST_DATA, ST_READ} port_state_t;
    typedef enum logic [2:0] {OP_NONE, OP_PROGRAM, OP_CLEAR, OP_CLEAR_ALL, OP_FILL_ALL} op_t;

endpackage

// [design/pin_filter.sv]
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes every bit of pin_raw is unrelated to mclk
module pin_filter
    import eeprom_pkg::*;
#(
    parameter int W = 4
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // pins and filtered levels
    input wire logic [W-1:0] pin_raw,
    output logic [W-1:0] pin_level
);

    // ==========================================================
    // per-pin stages
    generate
        if (W < 1) begin : g_bad
            $error("pin_filter needs at least one pin");
        end
        for (genvar i = 0; i < W; i++) begin : g_pin
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic level_reg;
            // first stage feeds only the second, to let metastability settle
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    level_reg <= 1'b0;
                end else begin
                    s1_reg <= pin_raw[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        level_reg <= s3_reg;
                    end
                end
            end
            assign pin_level[i] = level_reg;
        end
    endgenerate

endmodule

// [design/cycle_timer.sv]
// self-timed program cycle timer
// assumes start is a one-cycle pulse from the port logic on the same clock
module cycle_timer
    import eeprom_pkg::*;
#(
    parameter int CYCLES = PROG_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // control
    input wire logic start,
    output logic running
);

    localparam int CW = $clog2(CYCLES + 1);

    generate
        if (CYCLES < 1) begin : g_bad
            $error("cycle_timer needs at least one cycle");
        end
    endgenerate

    // ==========================================================
    // down counter
    logic [CW-1:0] count_reg;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            count_reg <= '0;
        end else if (start) begin
            count_reg <= CW'(CYCLES);
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign running = (count_reg != '0);

endmodule

// [sim/eeprom_port_assertions.sv]
// ==========================================================
// checker for the serial memory command port
// assumes a bind onto eeprom_port, seeing its ports only
module eeprom_port_checker #(
    parameter int PROG_CYCLES_P = 600
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // serial pins
    input wire logic chip_select,
    input wire logic shift_clock,
    input wire logic serial_in,
    input wire logic word_width_select,
    input wire logic serial_out,
    input wire logic serial_out_en,
    // state
    input wire logic cycle_busy,
    input wire logic program_enabled
);
    int busy_cnt_reg;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // a busy level far longer than a repetition can span, so count it
    always_ff @(posedge mclk) begin
        if (sys_rst || !cycle_busy) begin
            busy_cnt_reg <= 0;
        end else begin
            busy_cnt_reg <= busy_cnt_reg + 1;
        end
    end
    float_deselected_a: assert property (!chip_select [*8] |-> !serial_out_en)
        else $error("output driven while deselected");
    drive_needs_select_a: assert property ($rose(serial_out_en) |-> chip_select)
        else $error("output enabled without select");
    busy_low_a: assert property (cycle_busy && serial_out_en |-> !serial_out)
        else $error("ready shown while busy");
    ready_reported_a: assert property (serial_out_en && !cycle_busy && $past(cycle_busy)
        |-> ##[0:1] serial_out)
        else $error("ready not shown");
    busy_bounded_a: assert property (cycle_busy |-> busy_cnt_reg < PROG_CYCLES_P)
        else $error("timed cycle too long");
    sweep_length_a: assert property ($fell(cycle_busy) |-> busy_cnt_reg >= 512)
        else $error("timed cycle too short");
    busy_needs_enable_a: assert property ($rose(cycle_busy) |-> program_enabled)
        else $error("cycle ran with latch clear");
    busy_on_deselect_a: assert property ($rose(cycle_busy)
        |-> !chip_select && !$past(chip_select, 3))
        else $error("cycle began while selected");
    latch_steady_a: assert property (!chip_select [*8] |=> $stable(program_enabled))
        else $error("latch moved outside a frame");
    data_on_rise_a: assert property ($changed(serial_out) && serial_out_en
        && $past(serial_out_en) && !$past(cycle_busy) && !$past(cycle_busy, 2)
        |-> $past(shift_clock, 3))
        else $error("read data moved without a clock rise");
endmodule
bind eeprom_port eeprom_port_checker #(.PROG_CYCLES_P(PROG_CYCLES_P)) eeprom_port_checker_inst (
    .mclk(mclk), .sys_rst(sys_rst), .chip_select(chip_select), .shift_clock(shift_clock),
    .serial_in(serial_in), .word_width_select(word_width_select), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .cycle_busy(cycle_busy), .program_enabled(program_enabled)
);

// [sim/serial_host.sv]
// ==========================================================
// host model driving the three-wire serial bus of the memory
// assumes the caller spaces frames; pins move only after mclk edges
module serial_host (
    // clock
    input wire logic mclk,
    // pins towards the memory
    output logic chip_select,
    output logic shift_clock,
    output logic serial_in,
    // answer from the memory
    input wire logic serial_out,
    input wire logic serial_out_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic din_reg;
    logic idle_reg;
    initial begin
        chip_select = 1'b0;
        shift_clock = 1'b0;
        serial_in = 1'b0;
        din_reg = 1'b0;
        idle_reg = 1'b1;
    end
    // outside frames the data line toggles, so a stale bit is never trusted
    always @(posedge mclk) begin
        serial_in <= idle_reg ? ~serial_in : din_reg;
    end
    // a falling select after a full program frame launches the timed cycle
    task automatic select(input logic lvl);
        @(posedge mclk);
        chip_select <= lvl;
        idle_reg <= ~lvl;
        din_reg <= 1'b0;
        repeat (8) @(posedge mclk);
        #1;
    endtask
    // bit set up 7 cycles before the rising shift edge and held well after
    task automatic clock_bit(input logic b, output logic so, output logic so_en);
        @(posedge mclk);
        din_reg <= b;
        repeat (8) @(posedge mclk);
        shift_clock <= 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        // a floating line shows the inverse, so a stale bit never passes
        so = serial_out_en ? serial_out : ~serial_out;
        so_en = serial_out_en;
        @(posedge mclk);
        shift_clock <= 1'b0;
    endtask
endmodule

// [sim/eeprom_port_tb.sv]
// ==========================================================
// self-checking bench for the serial memory command port
// assumes a short timed cycle and the host model on the pins
module eeprom_port_tb
    import eeprom_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, sys_rst, word_width_select, chip_select, shift_clock, serial_in;
    logic serial_out, serial_out_en, cycle_busy, program_enabled;
    int mismatches = 0;
    int comparisons = 0;
    always #10 mclk = ~mclk;
    eeprom_port #(.PROG_CYCLES_P(600)) eeprom_port_inst (
        .mclk(mclk), .sys_rst(sys_rst), .chip_select(chip_select), .shift_clock(shift_clock),
        .serial_in(serial_in), .word_width_select(word_width_select), .serial_out(serial_out),
        .serial_out_en(serial_out_en), .cycle_busy(cycle_busy), .program_enabled(program_enabled)
    );
    serial_host serial_host_inst (
        .mclk(mclk), .chip_select(chip_select), .shift_clock(shift_clock),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en)
    );
    // ==========================================================
    // shared tasks
    task automatic report_and_stop;
        if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            mismatches++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    function automatic logic [8:0] ext_adr(input logic [1:0] code);
        return word_width_select ? {1'b0, code, 6'h00} : {code, 7'h00};
    endfunction
    // start bit, opcode, address; the last sample falls on the dummy slot
    task automatic head(input logic [1:0] op, input logic [8:0] adr, output logic so,
                        output logic en);
        serial_host_inst.select(1'b1);
        serial_host_inst.clock_bit(1'b1, so, en);
        serial_host_inst.clock_bit(op[1], so, en);
        serial_host_inst.clock_bit(op[0], so, en);
        for (int i = (word_width_select ? 7 : 8); i >= 0; i--) begin
            serial_host_inst.clock_bit(adr[i], so, en);
        end
    endtask
    task automatic command(input logic [1:0] op, input logic [8:0] adr, input logic [15:0] d,
                           input logic has_data);
        logic so, en;
        head(op, adr, so, en);
        for (int i = (has_data ? (word_width_select ? 15 : 7) : -1); i >= 0; i--) begin
            serial_host_inst.clock_bit(d[i], so, en);
        end
        serial_host_inst.select(1'b0);
    endtask
    task automatic ext(input logic [1:0] code);
        command(OPC_EXT, ext_adr(code), 16'h0000, 1'b0);
    endtask
    // select during the timed cycle, wait for ready, then float the output
    task automatic poll_ready;
        logic so, en;
        int t;
        t = 0;
        serial_host_inst.select(1'b1);
        check({13'h0, cycle_busy, serial_out_en, serial_out}, 16'h0006);
        while (serial_out !== 1'b1 && t < 1000) begin
            @(posedge mclk);
            #1;
            t++;
        end
        if (t == 1000) begin
            mismatches++;
            $display("BAD %0t ready never shown", $time);
            report_and_stop();
        end
        check({14'h0, cycle_busy, serial_out_en}, 16'h0001);
        serial_host_inst.clock_bit(1'b1, so, en);
        check({15'h0, en}, 16'h0000);
        serial_host_inst.select(1'b0);
    endtask
    // read two words in one frame; only the first carries the dummy zero
    task automatic read_two(input logic [8:0] adr, input logic [15:0] w0, input logic [15:0] w1);
        logic so, en;
        logic [15:0] got;
        head(OPC_READ, adr, so, en);
        check({14'h0, en, so}, 16'h0002);
        for (int k = 0; k < 2; k++) begin
            got = 16'h0000;
            for (int i = 0; i < (word_width_select ? 16 : 8); i++) begin
                serial_host_inst.clock_bit(1'b0, so, en);
                got = {got[14:0], so};
            end
            check(got, (k == 0) ? w0 : w1);
        end
        serial_host_inst.select(1'b0);
        check({15'h0, serial_out_en}, 16'h0000);
    endtask
    // ==========================================================
    // scenarios
    task automatic sc_protect;
        check({13'h0, program_enabled, serial_out_en, cycle_busy}, 16'h0000);
        ext(EXT_ENABLE);
        check({15'h0, program_enabled}, 16'h0001);
        ext(EXT_CLEAR_ALL);
        poll_ready();
        read_two(9'h000, 16'hFFFF, 16'hFFFF);
        ext(EXT_DISABLE);
        check({15'h0, program_enabled}, 16'h0000);
        command(OPC_PROGRAM, 9'h005, 16'h1234, 1'b1);
        check({15'h0, cycle_busy}, 16'h0000);
        read_two(9'h005, 16'hFFFF, 16'hFFFF);
    endtask
    task automatic sc_program;
        ext(EXT_ENABLE);
        command(OPC_PROGRAM, 9'h0FF, 16'hA5C3, 1'b1);
        poll_ready();
        command(OPC_PROGRAM, 9'h000, 16'h3C3C, 1'b1);
        poll_ready();
        command(OPC_PROGRAM, 9'h000, 16'hC3C3, 1'b1);
        poll_ready();
        check({15'h0, program_enabled}, 16'h0001);
        read_two(9'h0FF, 16'hA5C3, 16'hC3C3);
        command(OPC_CLEAR, 9'h0FF, 16'h0000, 1'b0);
        poll_ready();
        read_two(9'h0FF, 16'hFFFF, 16'hC3C3);
    endtask
    // reset in mid-run with the latch set; it must come back clear
    task automatic sc_reset;
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        check({13'h0, program_enabled, serial_out_en, cycle_busy}, 16'h0000);
    endtask
    task automatic sc_narrow;
        @(posedge mclk);
        word_width_select <= 1'b0;
        #1;
        ext(EXT_ENABLE);
        check({15'h0, program_enabled}, 16'h0001);
        command(OPC_EXT, ext_adr(EXT_FILL_ALL), 16'h005A, 1'b1);
        poll_ready();
        read_two(9'h1FF, 16'h005A, 16'h005A);
        @(posedge mclk);
        word_width_select <= 1'b1;
        #1;
        read_two(9'h0FF, 16'h5A5A, 16'h5A5A);
    endtask
    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        word_width_select = 1'b1;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        sc_protect();
        sc_program();
        sc_reset();
        sc_narrow();
        report_and_stop();
    end
endmodule
